// file: logic/symbol_serdes_loopback.sv
// Lane serialiser, oversampling deserialiser with clock recovery, inversion and loopbacks
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`include "serdes_consts.svh"

// Contract
// - Every 10-bit symbol leaves as single bits back to back with no gap inside it.
// - Bit zero of each symbol goes onto the line first, then the higher bits upward.
// - A parallel transfer carries one, two or four symbols, shifted out one after another.
// - The received stream is sampled with the receive clock and packed into 10-bit words.
// - Received words need not sit on symbol boundaries; later stages find them.
// - The sampling point follows the transitions of the received stream.
// - Each bit should be sampled near the middle of its period, within about 20 percent.
// - A readable status bit shows when bit synchronisation is achieved.
// - When inversion is requested every bit of each received word is inverted.
// - Near-end loopback feeds the serialiser output into the deserialiser input.
// - Far-end loopback feeds the received stream straight to the transmit driver.
module symbol_serdes_loopback
    import serdes_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [`ADDR_W-1:0]   reg_addr_i,
    input  wire logic [`DATA_W-1:0]   reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [`DATA_W-1:0]   reg_rdata_o,
    output logic                      irq_o,
    input  wire logic                 link_clk_i,
    input  wire logic [`PAR_W-1:0]    tx_data_i,
    input  wire logic                 tx_valid_i,
    output logic                      tx_ready_o,
    output logic                      tx_p_o,
    output logic                      tx_n_o,
    input  wire logic                 rx_p_i,
    input  wire logic                 rx_n_i,
    output logic      [`SYM_W-1:0]    rx_data_o,
    output logic                      rx_valid_o,
    input  wire logic                 invert_i,
    input  wire logic                 near_loop_i,
    input  wire logic                 far_loop_i
);

    // Pin synchronisers: link clock, rx pair, invert, near loop, far loop
    logic [5:0]                 sync1_ff;
    logic [5:0]                 sync2_ff;
    logic                       link_d_ff;
    logic                       rx_line_d_ff;
    logic                       rx_diff_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_ff <= 6'h00;
            sync2_ff <= 6'h00;
        end else begin
            sync1_ff <= {far_loop_i, near_loop_i, invert_i, rx_n_i, rx_p_i, link_clk_i};
            sync2_ff <= sync1_ff;
        end
    end

    wire logic link_s   = sync2_ff[0];
    wire logic rxp_s    = sync2_ff[1];
    wire logic rxn_s    = sync2_ff[2];
    wire logic invert_s = sync2_ff[3];
    wire logic near_s   = sync2_ff[4];
    wire logic far_s    = sync2_ff[5];

    wire logic link_tick = link_s & ~link_d_ff;
    // A pair that reads equal is undecided; hold the previous level through it
    wire logic rx_pin_bit = (rxp_s != rxn_s) ? rxp_s : rx_diff_ff;

    // Register file
    // Only the low bits of each register exist; the rest read as zero
    logic [2:0]                 ctrl_ff;
    logic [`EV_W-1:0]           irq_stat_ff;
    logic [`EV_W-1:0]           irq_mask_ff;
    logic [`DATA_W-1:0]         rdata_ff;
    lock_state_t                lock_ff;
    logic [`CNT_W-1:0]          left_ff;

    wire logic       tx_en    = ctrl_ff[`CTRL_TX_EN];
    wire sym_mode_t  mode     = sym_mode_t'(ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO]);
    wire logic       locked   = (lock_ff == LOCK_LOCKED);
    wire logic       sel_ctrl = (reg_addr_i == `OFS_CTRL);
    wire logic       sel_stat = (reg_addr_i == `OFS_STATUS);
    wire logic       sel_ist  = (reg_addr_i == `OFS_IRQ_STAT);
    wire logic       sel_imsk = (reg_addr_i == `OFS_IRQ_MASK);
    wire logic       wr_ist   = reg_wr_i & sel_ist;

    wire logic [`DATA_W-1:0] stat_word = {30'h0, (left_ff != `CNT_W'h0), locked};
    wire logic [`DATA_W-1:0] rd_mux =
        sel_ctrl ? {29'h0, ctrl_ff} :
        sel_stat ? stat_word :
        sel_ist  ? {29'h0, irq_stat_ff} :
        sel_imsk ? {29'h0, irq_mask_ff} : `DATA_W'h0;

    // Serialiser
    logic [`PAR_W-1:0]          shift_ff;
    logic                       tx_bit_ff;
    logic                       tx_line_ff;

    wire logic [`CNT_W-1:0] load_bits =
        (mode == MODE_FOUR) ? `BITS_FOUR :
        (mode == MODE_TWO)  ? `BITS_TWO  : `BITS_ONE;
    wire logic [`PAR_W-1:0] load_mask =
        (mode == MODE_FOUR) ? {`PAR_W{1'b1}} :
        (mode == MODE_TWO)  ? {20'h0, 20'hFFFFF} : {30'h0, 10'h3FF};
    wire logic tx_load     = tx_ready_o & tx_valid_i;
    // Underrun flags every idle slot while enabled, not only the first one
    wire logic tx_underrun = link_tick & tx_en & (left_ff == `CNT_W'h0) & ~tx_valid_i;

    // Ready only in bit slots with no bits left, so the next symbol follows the last bit with no gap
    assign tx_ready_o = link_tick & tx_en & (left_ff == `CNT_W'h0);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            shift_ff  <= `PAR_W'h0;
            left_ff   <= `CNT_W'h0;
            tx_bit_ff <= 1'b0;
        end else if (link_tick && left_ff != `CNT_W'h0) begin
            tx_bit_ff <= shift_ff[0];
            shift_ff  <= shift_ff >> 1;
            left_ff   <= left_ff - `CNT_W'h1;
        end else if (tx_load) begin
            tx_bit_ff <= tx_data_i[0];
            shift_ff  <= (tx_data_i & load_mask) >> 1;
            left_ff   <= load_bits - `CNT_W'h1;
        end
    end

    // Far-end loopback replaces the serialiser at the driver
    wire logic nxt_tx_line = far_s ? rx_pin_bit : tx_bit_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_line_ff <= 1'b0;
        end else begin
            tx_line_ff <= nxt_tx_line;
        end
    end

    assign tx_p_o = tx_line_ff;
    assign tx_n_o = ~tx_line_ff;

    // Clock recovery: a phase counter that restarts on every transition
    // Runs of more than about eleven equal bits drift past mid bit at this
    // oversampling ratio; the line code keeps runs far shorter than that
    logic [`PH_W-1:0]           phase_ff;
    logic [`GOOD_W-1:0]         good_ff;
    logic [`SYM_W-1:0]          word_ff;
    logic [`PH_W-1:0]           nbits_ff;

    // Near loopback taps the serialiser ahead of the driver register and the
    // pin synchronisers, so its words arrive a few cycles earlier than on a cable
    wire logic rx_line   = near_s ? tx_bit_ff : rx_pin_bit;
    wire logic rx_edge   = rx_line ^ rx_line_d_ff;
    wire logic sample_en = (phase_ff == `PH_W'(`BIT_MID));
    wire logic phase_end = (phase_ff == `PH_W'(`BIT_CYC - 1));
    // An edge far from the expected bit boundary means the phase is not yet tracked
    wire logic edge_ok   = (phase_ff <= `PH_W'(`BIT_TOL)) |
                           (phase_ff >= `PH_W'(`BIT_CYC - 1 - `BIT_TOL));
    wire logic good_full = (good_ff == `GOOD_W'(`LOCK_GOOD - 1));
    wire logic lock_gain = (lock_ff == LOCK_HUNT) & rx_edge & edge_ok & good_full;
    wire logic lock_lost = locked & rx_edge & ~edge_ok;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            link_d_ff    <= 1'b0;
            rx_line_d_ff <= 1'b0;
            rx_diff_ff   <= 1'b0;
            phase_ff     <= `PH_W'h0;
        end else begin
            link_d_ff    <= link_s;
            rx_line_d_ff <= rx_line;
            rx_diff_ff   <= rx_pin_bit;
            phase_ff     <= (rx_edge | phase_end) ? `PH_W'h0 : phase_ff + `PH_W'h1;
        end
    end

    // Lock needs a run of well placed edges, so a lone clean edge cannot claim it
    lock_state_t nxt_lock;
    logic [`GOOD_W-1:0] nxt_good;

    always_comb begin
        nxt_lock = lock_ff;
        nxt_good = good_ff;
        case (lock_ff)
            LOCK_HUNT: begin
                if (rx_edge && !edge_ok) begin
                    nxt_good = `GOOD_W'h0;
                end else if (lock_gain) begin
                    nxt_lock = LOCK_LOCKED;
                end else if (rx_edge) begin
                    nxt_good = good_ff + `GOOD_W'h1;
                end
            end
            LOCK_LOCKED: begin
                if (lock_lost) begin
                    nxt_lock = LOCK_HUNT;
                    nxt_good = `GOOD_W'h0;
                end
            end
            default: begin
                nxt_lock = LOCK_HUNT;
                nxt_good = `GOOD_W'h0;
            end
        endcase
    end

    // Deserialiser: no symbol alignment here, downstream word sync finds boundaries
    wire logic [`SYM_W-1:0] nxt_word  = {rx_line_d_ff, word_ff[`SYM_W-1:1]};
    wire logic              word_done = sample_en & (nbits_ff == `PH_W'(`SYM_W - 1));
    wire logic [`SYM_W-1:0] out_word  = invert_s ? ~nxt_word : nxt_word;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lock_ff    <= LOCK_HUNT;
            good_ff    <= `GOOD_W'h0;
            word_ff    <= `SYM_W'h0;
            nbits_ff   <= `PH_W'h0;
            rx_data_o  <= `SYM_W'h0;
            rx_valid_o <= 1'b0;
        end else begin
            lock_ff    <= nxt_lock;
            good_ff    <= nxt_good;
            rx_valid_o <= word_done;
            if (sample_en) begin
                word_ff  <= nxt_word;
                nbits_ff <= word_done ? `PH_W'h0 : nbits_ff + `PH_W'h1;
            end
            if (word_done) begin
                rx_data_o <= out_word;
            end
        end
    end

    // Registers and interrupt; a new event wins over a write-one clear
    wire logic [`EV_W-1:0] events   = {tx_underrun, lock_lost, lock_gain};
    wire logic [`EV_W-1:0] ist_clr  = wr_ist ? reg_wdata_i[`EV_W-1:0] : `EV_W'h0;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_ff     <= `CTRL_RST;
            irq_stat_ff <= `EV_RST;
            irq_mask_ff <= `EV_RST;
            rdata_ff    <= `DATA_W'h0;
        end else begin
            if (reg_wr_i && sel_ctrl) begin
                ctrl_ff <= reg_wdata_i[2:0];
            end
            if (reg_wr_i && sel_imsk) begin
                irq_mask_ff <= reg_wdata_i[`EV_W-1:0];
            end
            irq_stat_ff <= (irq_stat_ff & ~ist_clr) | events;
            rdata_ff    <= reg_rd_i ? rd_mux : `DATA_W'h0;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign irq_o       = |(irq_stat_ff & irq_mask_ff);

    // Checks
    // Mid-bit sampling and the first line bit after a load are spelt out in named sequences below
    sequence quiet_half_bit_s;
        rx_edge ##1 (!rx_edge)[*5];
    endsequence

    sequence tx_load_s;
        tx_load ##1 (tx_bit_ff == $past(tx_data_i[0]));
    endsequence

    tx_lsb_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tx_load |-> tx_load_s)
        else $error("first bit on the line is not bit zero");

    tx_no_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (link_tick && left_ff != `CNT_W'h0) |=> (left_ff == $past(left_ff) - `CNT_W'h1))
        else $error("bit count did not step inside a symbol");

    tx_width_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tx_load && mode == MODE_FOUR) |=> (left_ff == `CNT_W'h27))
        else $error("four symbol load has the wrong length");

    tx_ready_slot_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (link_tick && tx_en && left_ff == `CNT_W'h0 && tx_valid_i) |=>
            (tx_bit_ff == $past(tx_data_i[0])))
        else $error("next transfer did not follow the last bit at once");

    rx_mid_sample_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        quiet_half_bit_s |=> sample_en)
        else $error("sample not taken mid bit after an edge");

    rx_word_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        word_done |=> rx_valid_o ##1 !rx_valid_o)
        else $error("word strobe wrong after ten samples");

    rx_invert_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (word_done && invert_s) |=> (rx_data_o == ~$past(nxt_word)))
        else $error("received word not inverted");

    far_loop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        far_s |=> (tx_p_o == $past(rx_pin_bit)) && (tx_n_o != tx_p_o))
        else $error("far loopback does not reach the driver");

    near_loop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (near_s && $past(near_s)) |-> (rx_line_d_ff == $past(tx_bit_ff)))
        else $error("near loopback does not reach the deserialiser");

    lock_status_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        lock_gain |=> locked ##1 stat_word[`STAT_LOCKED])
        else $error("lock status not shown after synchronisation");

    ctrl_sync_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(invert_i) |=> !invert_s ##1 invert_s)
        else $error("inversion request skipped its synchroniser");

    tx_bit_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !$past(link_tick) |-> $stable(tx_bit_ff))
        else $error("line bit changed between bit slots");

    far_loop_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !far_s |=> (tx_p_o == $past(tx_bit_ff)))
        else $error("driver does not carry the serialiser outside far loopback");

    rx_word_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_valid_o |=> (!rx_valid_o)[*8])
        else $error("words closer than ten samples apart");

    rx_sample_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sample_en |=> (!sample_en)[*5])
        else $error("bit sampled twice within one bit period");

    rx_plain_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (word_done && !invert_s) |=> (rx_data_o == $past(nxt_word)))
        else $error("received word altered without inversion");

    lock_lost_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        lock_lost |=> irq_stat_ff[`EV_LOCK_LOST])
        else $error("loss of bit lock not recorded");

    underrun_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tx_underrun |=> irq_stat_ff[`EV_UNDERRUN])
        else $error("idle slot on the line not recorded");

endmodule : symbol_serdes_loopback

// file: inc/serdes_consts.svh
// Constants for the symbol serialiser, deserialiser and loopback block
`ifndef SERDES_CONSTS_SVH
`define SERDES_CONSTS_SVH

`define SYM_W          10
`define PAR_W          40
`define CNT_W          6
`define ADDR_W         8
`define DATA_W         32

`define CLK_NS         5
`define LINK_BIT_NS    48
`define BIT_CYC        ((`LINK_BIT_NS * 2 + `CLK_NS) / (2 * `CLK_NS))
`define BIT_MID        (`BIT_CYC / 2)
`define CENTRE_PCT     20
`define BIT_TOL        ((`BIT_CYC * `CENTRE_PCT) / 100)
`define LOCK_GOOD      8
`define PH_W           4
`define GOOD_W         4

`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_IRQ_STAT   8'h08
`define OFS_IRQ_MASK   8'h0C

`define CTRL_TX_EN     0
`define CTRL_MODE_LO   1
`define CTRL_MODE_HI   2
`define CTRL_RST       3'h0

`define STAT_LOCKED    0
`define STAT_TX_BUSY   1

`define EV_LOCK_GAIN   0
`define EV_LOCK_LOST   1
`define EV_UNDERRUN    2
`define EV_W           3
`define EV_RST         3'h0

`define BITS_ONE       6'h0A
`define BITS_TWO       6'h14
`define BITS_FOUR      6'h28

`endif

// file: inc/serdes_pkg.sv
// Types shared by the symbol serialiser, deserialiser and loopback block
package serdes_pkg;

    typedef enum logic [1:0] {
        LOCK_HUNT   = 2'h0,
        LOCK_LOCKED = 2'h1
    } lock_state_t;

    typedef enum logic [1:0] {
        MODE_ONE  = 2'h0,
        MODE_TWO  = 2'h1,
        MODE_FOUR = 2'h2
    } sym_mode_t;

endpackage : serdes_pkg

// file: test/remote_lane_model.sv
// Remote lane partner: drives the receive pair and records the transmit line
`timescale 1ns/100ps
module remote_lane_model #(
    parameter int BIT_NS = 48
) (
    input  wire logic link_clk_i,
    input  wire logic tx_p_i,
    output logic      rx_p_o,
    output logic      rx_n_o
);
    logic send_q[$];
    logic cap_q[$];
    logic loop_q[$];

    assign rx_n_o = ~rx_p_o;

    // Idle line toggles, so a stale level never passes for payload
    initial begin
        rx_p_o = 1'b0;
        forever begin
            rx_p_o = (send_q.size() > 0) ? send_q.pop_front() : ~rx_p_o;
            #40;
            loop_q.push_back(tx_p_i);
            #(BIT_NS - 40);
        end
    end

    // A bit launched on one link edge is settled well before the next one
    always @(posedge link_clk_i) begin
        cap_q.push_back(tx_p_i);
    end
endmodule : remote_lane_model

// file: test/symbol_serdes_loopback_tb_top.sv
// Self-checking bench for the serialiser, deserialiser and loopback block
`timescale 1ns/100ps
`include "serdes_consts.svh"
module symbol_serdes_loopback_tb_top
    import serdes_pkg::*;
;
    logic                clk_i;
    logic                rst_n_i;
    logic                link_clk_i;
    logic [`ADDR_W-1:0]  reg_addr_i;
    logic [`DATA_W-1:0]  reg_wdata_i;
    logic [`DATA_W-1:0]  reg_rdata_o;
    logic                reg_wr_i;
    logic                reg_rd_i;
    logic                irq_o;
    logic [`PAR_W-1:0]   tx_data_i;
    logic                tx_valid_i;
    logic                tx_ready_o;
    logic                tx_p_o;
    logic                tx_n_o;
    logic                rx_p_i;
    logic                rx_n_i;
    logic [`SYM_W-1:0]   rx_data_o;
    logic                rx_valid_o;
    logic                invert_i;
    logic                near_loop_i;
    logic                far_loop_i;
    int                  errors;
    int                  checks;
    int unsigned         seed_v;
    logic [`DATA_W-1:0]  rd_v;
    logic                exp_q[$];
    logic                got_q[$];
    int                  nsym[4] = '{1, 2, 4, 1};

    symbol_serdes_loopback dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .link_clk_i(link_clk_i),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .tx_p_o(tx_p_o), .tx_n_o(tx_n_o), .rx_p_i(rx_p_i), .rx_n_i(rx_n_i),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .invert_i(invert_i),
        .near_loop_i(near_loop_i), .far_loop_i(far_loop_i)
    );

    remote_lane_model far_u (
        .link_clk_i(link_clk_i), .tx_p_i(tx_p_o), .rx_p_o(rx_p_i), .rx_n_o(rx_n_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Odd start offset keeps the link clock out of phase with clk_i
    initial begin
        link_clk_i = 1'b0;
        #1.3;
        forever #24 link_clk_i = ~link_clk_i;
    end

    always @(negedge clk_i) begin
        if (rx_valid_o === 1'b1) begin
            for (int i = 0; i < `SYM_W; i++) begin
                got_q.push_back(rx_data_o[i]);
            end
        end
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    // Words are not symbol aligned, so the run is searched at any offset
    function automatic bit has_seq(input logic e[$], input logic g[$], input logic inv);
        bit ok;
        for (int i = 0; i + e.size() <= g.size(); i++) begin
            ok = 1'b1;
            for (int j = 0; j < e.size(); j++) begin
                if (g[i + j] !== (e[j] ^ inv)) begin
                    ok = 1'b0;
                end
            end
            if (ok) begin
                return 1'b1;
            end
        end
        return 1'b0;
    endfunction : has_seq

    task automatic chk_stream(input string nm, input logic e[$], ref logic g[$],
                              input logic inv);
        bit hit;
        hit = 1'b0;
        for (int c = 0; c < 100 && !hit; c++) begin
            repeat (50) @(posedge clk_i);
            hit = has_seq(e, g, inv);
        end
        checks++;
        if (!hit) begin
            errors++;
            $display("CHECK FAILED %s expected %0d bit run seen %0d bits", nm, e.size(),
                     g.size());
            wrap_up();
        end
    endtask : chk_stream

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        @(negedge clk_i);
        d = reg_rdata_o;
    endtask : reg_rd

    // Entered just after a clock edge; returns just after the edge that took the data
    task automatic tx_xfer(input int n);
        logic [`PAR_W-1:0] d;
        int                k;
        d = `PAR_W'({$urandom(), $urandom()});
        tx_data_i  <= d;
        tx_valid_i <= 1'b1;
        for (k = 0; k < n * `SYM_W; k++) begin
            exp_q.push_back(d[k]);
        end
        for (k = 0; k < 1000; k++) begin
            @(negedge clk_i);
            if (tx_ready_o === 1'b1) break;
        end
        if (k == 1000) begin
            errors++;
            $display("CHECK FAILED tx ready expected %0d seen %0d", 1, 0);
            wrap_up();
        end
        @(posedge clk_i);
    endtask : tx_xfer

    // A forced toggle every fourth bit bounds run length for the recovery
    task automatic rx_send(input int n);
        logic b;
        b = 1'b0;
        exp_q.delete();
        got_q.delete();
        for (int i = 0; i < n; i++) begin
            b = (i % 4 == 3) ? ~b : 1'($urandom());
            exp_q.push_back(b);
            far_u.send_q.push_back(b);
        end
    endtask : rx_send

    initial begin
        rst_n_i     = 1'b0;
        reg_addr_i  = '0;
        reg_wdata_i = '0;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        tx_data_i   = '0;
        tx_valid_i  = 1'b0;
        invert_i    = 1'b0;
        near_loop_i = 1'b0;
        far_loop_i  = 1'b0;
        errors      = 0;
        checks      = 0;
        seed_v      = $urandom(32'h748A);
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        reg_rd(`OFS_CTRL, rd_v);
        chk_val("ctrl reset", 32'h0, rd_v);
        reg_rd(`OFS_IRQ_MASK, rd_v);
        chk_val("mask reset", 32'h0, rd_v);
        reg_wr(8'h10, 32'hFFFF_FFFF);
        reg_rd(8'h10, rd_v);
        chk_val("unmapped", 32'h0, rd_v);
        rx_send(60);
        chk_stream("rx words", exp_q, got_q, 1'b0);
        reg_rd(`OFS_IRQ_STAT, rd_v);
        chk_val("lock event", 32'h1, rd_v & 32'h1);
        chk_val("irq masked", 32'h0, {31'h0, irq_o});
        reg_wr(`OFS_IRQ_MASK, 32'h1);
        @(negedge clk_i);
        chk_val("irq raised", 32'h1, {31'h0, irq_o});
        reg_wr(`OFS_IRQ_STAT, 32'h1);
        @(negedge clk_i);
        chk_val("irq cleared", 32'h0, {31'h0, irq_o});
        reg_rd(`OFS_STATUS, rd_v);
        chk_val("bit lock", 32'h1, rd_v & 32'h1);
        chk_val("tx idle", 32'h0, rd_v & 32'h2);
        @(posedge clk_i);
        invert_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rx_send(60);
        chk_stream("rx inverted", exp_q, got_q, 1'b1);
        invert_i <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            reg_wr(`OFS_CTRL, {29'h0, 2'(m), 1'b1});
            exp_q.delete();
            far_u.cap_q.delete();
            tx_xfer(nsym[m]);
            tx_xfer(nsym[m]);
            tx_valid_i <= 1'b0;
            chk_stream("tx line", exp_q, far_u.cap_q, 1'b0);
        end
        reg_rd(`OFS_IRQ_STAT, rd_v);
        chk_val("underrun", 32'h4, rd_v & 32'h4);
        @(posedge clk_i);
        near_loop_i <= 1'b1;
        reg_wr(`OFS_CTRL, {29'h0, MODE_FOUR, 1'b1});
        exp_q.delete();
        got_q.delete();
        tx_xfer(4);
        tx_xfer(4);
        tx_valid_i <= 1'b0;
        chk_stream("near loop", exp_q, got_q, 1'b0);
        near_loop_i <= 1'b0;
        far_loop_i  <= 1'b1;
        repeat (4) @(posedge clk_i);
        rx_send(60);
        far_u.loop_q.delete();
        chk_stream("far loop", exp_q, far_u.loop_q, 1'b0);
        @(negedge clk_i);
        chk_val("tx pair", {31'h0, ~tx_p_o}, {31'h0, tx_n_o});
        wrap_up();
    end
endmodule : symbol_serdes_loopback_tb_top
